// ===== sip_host_model.sv
// host model: step pulses on request, wake delay kept
`timescale 1ns/1ps
module sip_host_model #(
  parameter int WAKE_CYC = 20000
) (
  input wire logic aclk,
  input wire logic sleep_pin,
  input wire logic go,
  output logic     step_pin,
  output logic     busy
);
  int wake_cnt;
  int ph;
  initial begin
    step_pin = 1'b0;
    busy = 1'b0;
    wake_cnt = 0;
    ph = 0;
  end
  // two cycles high, two low; held back until settled after sleep
  always @(posedge aclk) begin
    if (sleep_pin) begin
      wake_cnt <= WAKE_CYC;
    end else if (wake_cnt != 0) begin
      wake_cnt <= wake_cnt - 1;
    end
    if (go && !busy) begin
      busy <= 1'b1;
      ph <= 0;
    end else if (busy && wake_cnt == 0 && !sleep_pin) begin
      ph <= ph + 1;
      step_pin <= ph < 2;
      busy <= ph != 3;
    end
  end
endmodule

// ===== sip_pkg.sv
// shared constants and types of the stepper indexer and pwm regulator
package sip_pkg;
  localparam int CLK_PERIOD_NS   = 50;
  localparam int T_OFF_BASE_NS   = 20000;
  localparam int T_OFF_STEP_NS   = 5000;
  localparam int T_BLANK_MIN_NS  = 250;
  localparam int T_BLANK_STEP_NS = 500;
  localparam int T_WAKE_US       = 1000;
  localparam int CNT_W           = 11;
  localparam logic [CNT_W-1:0] OFF_BASE_CYC   = CNT_W'((T_OFF_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] OFF_STEP_CYC   = CNT_W'((T_OFF_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] BLANK_MIN_CYC  = CNT_W'((T_BLANK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] BLANK_STEP_CYC = CNT_W'((T_BLANK_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_MAIN_CONTROL              = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_SECONDARY_CONFIG_REGISTER = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PEAK_CURRENT_REGISTER     = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STEP_POSITION_REGISTER    = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_STATUS                    = 8'h10;

  localparam int EN_BIT    = 0;
  localparam int DIR_BIT   = 1;
  localparam int STEP_BIT  = 2;
  localparam int MS_LSB    = 3;
  localparam int OT_LSB    = 6;
  localparam int SE_BIT    = 0;
  localparam int BT_LSB    = 1;
  localparam int PEAK_LSB  = 0;
  localparam int ST_EN_BIT = 0;
  localparam int ST_SL_BIT = 1;
  localparam int ST_PWM_LSB = 2;

  localparam logic       EN_RST   = 1'b0;
  localparam logic       DIR_RST  = 1'b0;
  localparam logic [2:0] MS_RST   = 3'h3;
  localparam logic [2:0] OT_RST   = 3'h4;
  localparam logic       SE_RST   = 1'b0;
  localparam logic [2:0] BT_RST   = 3'h4;
  localparam logic [5:0] PEAK_RST = 6'h09;

  localparam int POS_W = 7;
  localparam logic [POS_W-1:0] POS_RST     = 7'h10;
  localparam logic [POS_W-1:0] POS_QUARTER = 7'h20;
  localparam logic [2:0]       MS_FINEST   = 3'h5;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    PWM_ON     = 2'b00,
    PWM_SLOW   = 2'b01,
    PWM_FAST   = 2'b11,
    PWM_REFILL = 2'b10
  } sip_pwm_state_t;

  typedef struct packed {
    logic hs1;
    logic ls1;
    logic hs2;
    logic ls2;
  } sip_gate_t;

  typedef struct packed {
    logic        neg;
    logic [14:0] level;
  } sip_dac_t;

  typedef struct packed {
    logic       en_bit;
    logic       dir_bit;
    logic [2:0] microstep_resolution_field;
    logic [2:0] off_time_field;
    logic       single_ended_winding_select;
    logic [2:0] blank_duration_field;
    logic [5:0] peak_current_field;
  } sip_cfg_t;
endpackage

// ===== sip_props.sv
// port checks for the stepper core
`timescale 1ns/1ps
module sip_props (
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic               active_low_init_pin_n,
  input wire logic               sleep_pin,
  input wire logic               s_axi_bvalid,
  input wire sip_pkg::sip_gate_t gate_a,
  input wire sip_pkg::sip_gate_t gate_b,
  input wire logic               charge_pump_en,
  input wire logic               bridge_enabled
);
  import sip_pkg::*;
  logic [10:0] slow_cnt_r;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !active_low_init_pin_n);
  // length of the current slow decay run on winding a
  always_ff @(posedge aclk) begin
    if (!aresetn || gate_a != 4'h5) begin
      slow_cnt_r <= 11'h000;
    end else if (slow_cnt_r != 11'h7ff) begin
      slow_cnt_r <= slow_cnt_r + 11'h001;
    end
  end
  AST_INIT_QUIET: assert property (disable iff (!aresetn)
    !active_low_init_pin_n |=> gate_a == 4'h0 && gate_b == 4'h0 && !bridge_enabled && !s_axi_bvalid)
    else $error("outputs live in init");
  AST_SLEEP_PUMP: assert property (sleep_pin |=> !charge_pump_en) else $error("pump on asleep");
  AST_SLEEP_BRIDGE: assert property (sleep_pin |=> !bridge_enabled) else $error("bridge on asleep");
  AST_OFF_GATES: assert property (!bridge_enabled [*2] |-> gate_a == 4'h0 && gate_b == 4'h0)
    else $error("gates on while off");
  AST_GATE_SET: assert property (gate_a inside {4'h0, 4'h9, 4'h6, 4'h5, 4'h8, 4'h4, 4'h2, 4'h1})
    else $error("bad gate pattern");
  AST_BLANK: assert property ($past(gate_a) == 4'h5 && gate_a == 4'h9 |=> (gate_a != 4'h5) [*4])
    else $error("trip in blank");
  AST_SLOW_HOLD: assert property ($past(gate_a) == 4'h9 && gate_a == 4'h5 |=> (gate_a inside {4'h5, 4'h0}) [*8])
    else $error("slow decay cut");
  AST_OFF_SPAN: assert property ($past(gate_a) == 4'h5 && gate_a == 4'h9 |-> $past(slow_cnt_r) > 11'h185)
    else $error("off time short");
  cover property (gate_a == 4'h6);
  cover property (gate_a == 4'h8);
  cover property ($rose(bridge_enabled));
endmodule

// ===== sip_sine_rom.sv
// quarter-wave sine table with two registered read ports
`timescale 1ns/1ps
module sip_sine_rom (
  input  wire logic       aclk,
  input  wire logic [5:0] idx_a,
  input  wire logic [5:0] idx_b,
  output logic      [7:0] mag_a,
  output logic      [7:0] mag_b
);
  function automatic logic [7:0] sine_at(input logic [5:0] k);
    logic [7:0] v;
    v = 8'hff;
    case (k)
      6'h00: v = 8'h00; 6'h01: v = 8'h0d; 6'h02: v = 8'h19; 6'h03: v = 8'h25;
      6'h04: v = 8'h32; 6'h05: v = 8'h3e; 6'h06: v = 8'h4a; 6'h07: v = 8'h56;
      6'h08: v = 8'h62; 6'h09: v = 8'h6d; 6'h0a: v = 8'h78; 6'h0b: v = 8'h83;
      6'h0c: v = 8'h8e; 6'h0d: v = 8'h98; 6'h0e: v = 8'ha2; 6'h0f: v = 8'hab;
      6'h10: v = 8'hb4; 6'h11: v = 8'hbd; 6'h12: v = 8'hc5; 6'h13: v = 8'hcd;
      6'h14: v = 8'hd4; 6'h15: v = 8'hdb; 6'h16: v = 8'he1; 6'h17: v = 8'he7;
      6'h18: v = 8'hec; 6'h19: v = 8'hf0; 6'h1a: v = 8'hf4; 6'h1b: v = 8'hf7;
      6'h1c: v = 8'hfa; 6'h1d: v = 8'hfc; 6'h1e: v = 8'hfe; 6'h1f: v = 8'hff;
      default: v = 8'hff;
    endcase
    return v;
  endfunction

  always_ff @(posedge aclk) begin
    mag_a <= sine_at(idx_a);
    mag_b <= sine_at(idx_b);
  end
endmodule

// ===== sip_stepper_core.sv
// stepper indexer, translator, pwm current regulator and axi4-lite register slave
// Overview of operation
// - init pin low resets registers, bridges, position
// - sleep stops pump, bridges, ignores inputs
// - enable is gate pin xor gate bit
// - step pin rise while enabled or step bit advances
// - direction is sense pin xor sense bit
// - step position register readable and writable
// - translator gives magnitude and sign per winding
// - resolution field selects full to 1/32 step
// - bipolar cycle starts with diagonal pair on
// - comparator ignored for mask interval, minimum on
// - threshold reached: slow decay for off time
// - still high after decay: fast, then slow
// - off time field sets 20 to 55us
// - unipolar drives one low side, no fast
// - unipolar sign picks terminal one or two
// - unipolar trip freewheels high side, then restarts
// - single-ended select bit chooses unipolar mode
// - blank field sets 250ns to 3.5us mask
// - six-bit peak field scales full current
`timescale 1ns/1ps
module sip_stepper_core (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [sip_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [sip_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  active_low_init_pin_n,
  input  wire logic                  sleep_pin,
  input  wire logic                  output_gate_pin,
  input  wire logic                  step_pin,
  input  wire logic                  rotation_sense_pin,
  input  wire logic [1:0]            current_at_threshold,
  output sip_pkg::sip_gate_t         gate_a,
  output sip_pkg::sip_gate_t         gate_b,
  output sip_pkg::sip_dac_t          dac_a,
  output sip_pkg::sip_dac_t          dac_b,
  output logic                       charge_pump_en,
  output logic                       bridge_enabled
);
  import sip_pkg::*;

  logic                rst;
  sip_cfg_t            cfg_r;
  logic [POS_W-1:0]    pos_r;
  logic                step_pin_d_r;
  logic                sw_step_r;
  logic                out_en;
  logic                step_evt;
  logic                dir_up;
  logic [POS_W-1:0]    pos_nxt;
  logic                aw_got_r;
  logic                w_got_r;
  logic [ADDR_W-1:0]   awaddr_r;
  logic [31:0]         wdata_r;
  logic [3:0]          wstrb_r;
  logic                bvalid_r;
  logic [1:0]          bresp_r;
  logic                rvalid_r;
  logic [31:0]         rdata_r;
  logic [1:0]          rresp_r;
  logic                wr_fire;
  logic [31:0]         wr_val;
  logic [31:0]         old_val;
  logic                wr_hit;
  logic [POS_W-1:0]    ang_b;
  logic [6:0]          fold_a;
  logic [6:0]          fold_b;
  logic [7:0]          mag_a;
  logic [7:0]          mag_b;
  logic [1:0]          neg_r;
  sip_pwm_state_t      st_r [2];
  sip_pwm_state_t      st_nxt [2];
  logic [CNT_W-1:0]    cnt_r [2];
  logic [CNT_W-1:0]    cnt_nxt [2];
  sip_gate_t           gate_r [2];
  logic [CNT_W-1:0]    off_cyc;
  logic [CNT_W-1:0]    blank_cyc;

  // merges write data into a register word under the byte strobes
  function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // table entries moved per step event in the selected mode
  function automatic logic [POS_W-1:0] step_size(input logic [2:0] ms);
    logic [POS_W-1:0] s;
    s = 7'h01;
    if (ms <= MS_FINEST) begin
      s = 7'h01 << (MS_FINEST - ms);
    end
    return s;
  endfunction

  // folds a table position onto the quarter wave: sign bit and index
  function automatic logic [6:0] fold(input logic [POS_W-1:0] p);
    logic [6:0] f;
    f = {p[6], 1'b0, p[4:0]};
    if (p[5]) begin
      f[5:0] = 6'h20 - {1'b0, p[4:0]};
    end
    return f;
  endfunction

  // bridge drive for a state, sign and mode
  function automatic sip_gate_t gate_of(input sip_pwm_state_t s, input logic neg, input logic se, input logic en);
    sip_gate_t g;
    g = '0;
    if (en) begin
      if (se) begin
        if (s == PWM_ON) begin
          g.ls1 = ~neg;
          g.ls2 = neg;
        end else begin
          g.hs1 = ~neg;
          g.hs2 = neg;
        end
      end else begin
        case (s)
          PWM_ON: begin
            g.hs1 = ~neg;
            g.ls2 = ~neg;
            g.hs2 = neg;
            g.ls1 = neg;
          end
          PWM_FAST: begin
            g.hs1 = neg;
            g.ls2 = neg;
            g.hs2 = ~neg;
            g.ls1 = ~neg;
          end
          default: begin
            g.ls1 = 1'b1;
            g.ls2 = 1'b1;
          end
        endcase
      end
    end
    return g;
  endfunction

  assign rst     = ~aresetn | ~active_low_init_pin_n;
  assign out_en  = output_gate_pin ^ cfg_r.en_bit;
  assign dir_up  = rotation_sense_pin ^ cfg_r.dir_bit;
  assign off_cyc = OFF_BASE_CYC + CNT_W'(OFF_STEP_CYC * cfg_r.off_time_field);
  assign blank_cyc = (cfg_r.blank_duration_field == 3'h0) ? BLANK_MIN_CYC :
                     CNT_W'(BLANK_STEP_CYC * cfg_r.blank_duration_field);

  // step pin edges count only with the bridges on; nothing counts asleep
  assign step_evt = ~sleep_pin & ((out_en & step_pin & ~step_pin_d_r) | sw_step_r);
  assign pos_nxt  = dir_up ? pos_r + step_size(cfg_r.microstep_resolution_field)
                           : pos_r - step_size(cfg_r.microstep_resolution_field);

  // axi write path
  assign s_axi_awready = ~aw_got_r & ~bvalid_r;
  assign s_axi_wready  = ~w_got_r & ~bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign wr_fire = aw_got_r & w_got_r & ~bvalid_r;

  always_comb begin
    old_val = 32'h0;
    wr_hit  = 1'b1;
    case (awaddr_r)
      OFS_MAIN_CONTROL: begin
        old_val[EN_BIT] = cfg_r.en_bit;
        old_val[DIR_BIT] = cfg_r.dir_bit;
        old_val[MS_LSB +: 3] = cfg_r.microstep_resolution_field;
        old_val[OT_LSB +: 3] = cfg_r.off_time_field;
      end
      OFS_SECONDARY_CONFIG_REGISTER: begin
        old_val[SE_BIT] = cfg_r.single_ended_winding_select;
        old_val[BT_LSB +: 3] = cfg_r.blank_duration_field;
      end
      OFS_PEAK_CURRENT_REGISTER: old_val[PEAK_LSB +: 6] = cfg_r.peak_current_field;
      OFS_STEP_POSITION_REGISTER: old_val[POS_W-1:0] = pos_r;
      default: wr_hit = 1'b0;
    endcase
  end

  assign wr_val = merge_strb(old_val, wdata_r, wstrb_r);

  always_ff @(posedge aclk) begin
    if (rst) begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awaddr_r <= '0;
      wdata_r  <= 32'h0;
      wstrb_r  <= 4'h0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= {s_axi_awaddr[ADDR_W-1:2], 2'b00};
      end else if (wr_fire) begin
        aw_got_r <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_got_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (rst) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r  <= (wr_hit & ~sleep_pin) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // configuration registers; writes are dropped while asleep
  always_ff @(posedge aclk) begin
    if (rst) begin
      cfg_r.en_bit <= EN_RST;
      cfg_r.dir_bit <= DIR_RST;
      cfg_r.microstep_resolution_field <= MS_RST;
      cfg_r.off_time_field <= OT_RST;
      cfg_r.single_ended_winding_select <= SE_RST;
      cfg_r.blank_duration_field <= BT_RST;
      cfg_r.peak_current_field <= PEAK_RST;
    end else if (wr_fire & ~sleep_pin) begin
      case (awaddr_r)
        OFS_MAIN_CONTROL: begin
          cfg_r.en_bit <= wr_val[EN_BIT];
          cfg_r.dir_bit <= wr_val[DIR_BIT];
          cfg_r.microstep_resolution_field <= wr_val[MS_LSB +: 3];
          cfg_r.off_time_field <= wr_val[OT_LSB +: 3];
        end
        OFS_SECONDARY_CONFIG_REGISTER: begin
          cfg_r.single_ended_winding_select <= wr_val[SE_BIT];
          cfg_r.blank_duration_field <= wr_val[BT_LSB +: 3];
        end
        OFS_PEAK_CURRENT_REGISTER: cfg_r.peak_current_field <= wr_val[PEAK_LSB +: 6];
        default: cfg_r <= cfg_r;
      endcase
    end
  end

  // software step request, one-cycle pulse on a write of one
  always_ff @(posedge aclk) begin
    if (rst) begin
      sw_step_r <= 1'b0;
    end else begin
      sw_step_r <= wr_fire & ~sleep_pin & (awaddr_r == OFS_MAIN_CONTROL) & wstrb_r[0] & wdata_r[STEP_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (rst) begin
      step_pin_d_r <= 1'b0;
    end else begin
      step_pin_d_r <= step_pin;
    end
  end

  // position: a direct write wins over a step in the same cycle
  always_ff @(posedge aclk) begin
    if (rst) begin
      pos_r <= POS_RST;
    end else if (wr_fire & ~sleep_pin & (awaddr_r == OFS_STEP_POSITION_REGISTER)) begin
      pos_r <= wr_val[POS_W-1:0];
    end else if (step_evt) begin
      pos_r <= pos_nxt;
    end
  end

  // axi read path
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  always_ff @(posedge aclk) begin
    if (rst) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0;
      rresp_r  <= RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      rvalid_r <= 1'b1;
      rresp_r  <= RESP_OKAY;
      rdata_r  <= 32'h0;
      case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
        OFS_MAIN_CONTROL: begin
          rdata_r[EN_BIT] <= cfg_r.en_bit;
          rdata_r[DIR_BIT] <= cfg_r.dir_bit;
          rdata_r[MS_LSB +: 3] <= cfg_r.microstep_resolution_field;
          rdata_r[OT_LSB +: 3] <= cfg_r.off_time_field;
        end
        OFS_SECONDARY_CONFIG_REGISTER: begin
          rdata_r[SE_BIT] <= cfg_r.single_ended_winding_select;
          rdata_r[BT_LSB +: 3] <= cfg_r.blank_duration_field;
        end
        OFS_PEAK_CURRENT_REGISTER: rdata_r[PEAK_LSB +: 6] <= cfg_r.peak_current_field;
        OFS_STEP_POSITION_REGISTER: rdata_r[POS_W-1:0] <= pos_r;
        OFS_STATUS: begin
          rdata_r[ST_EN_BIT] <= bridge_enabled;
          rdata_r[ST_SL_BIT] <= sleep_pin;
          rdata_r[ST_PWM_LSB +: 4] <= {st_r[1], st_r[0]};
        end
        default: rresp_r <= RESP_SLVERR;
      endcase
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // translator: winding a follows sine, winding b a quarter ahead
  assign ang_b  = pos_r + POS_QUARTER;
  assign fold_a = fold(pos_r);
  assign fold_b = fold(ang_b);

  sip_sine_rom u_rom (
    .aclk  (aclk),
    .idx_a (fold_a[5:0]),
    .idx_b (fold_b[5:0]),
    .mag_a (mag_a),
    .mag_b (mag_b)
  );

  always_ff @(posedge aclk) begin
    if (rst) begin
      neg_r <= 2'b00;
    end else begin
      neg_r <= {fold_b[6], fold_a[6]};
    end
  end

  // dac codes: table magnitude scaled by the peak current code
  always_ff @(posedge aclk) begin
    if (rst) begin
      dac_a <= '0;
      dac_b <= '0;
    end else begin
      dac_a.neg   <= neg_r[0];
      dac_a.level <= 15'(mag_a * ({1'b0, cfg_r.peak_current_field} + 7'h01));
      dac_b.neg   <= neg_r[1];
      dac_b.level <= 15'(mag_b * ({1'b0, cfg_r.peak_current_field} + 7'h01));
    end
  end

  // bridges switch only when enabled and awake; the charge pump follows the sleep pin alone
  always_ff @(posedge aclk) begin
    if (rst) begin
      bridge_enabled <= 1'b0;
      charge_pump_en <= 1'b0;
    end else begin
      bridge_enabled <= out_en & ~sleep_pin;
      charge_pump_en <= ~sleep_pin;
    end
  end

  // one constant-off-time regulator per winding
  for (genvar w = 0; w < 2; w++) begin : g_pwm
    always_comb begin
      st_nxt[w]  = st_r[w];
      cnt_nxt[w] = cnt_r[w];
      case (st_r[w])
        PWM_ON: begin
          if (cnt_r[w] != '0) begin
            cnt_nxt[w] = cnt_r[w] - 1'b1;
          end else if (current_at_threshold[w]) begin
            st_nxt[w]  = PWM_SLOW;
            cnt_nxt[w] = off_cyc - 1'b1;
          end
        end
        PWM_SLOW: begin
          if (cnt_r[w] != '0) begin
            cnt_nxt[w] = cnt_r[w] - 1'b1;
          end else if (~cfg_r.single_ended_winding_select & current_at_threshold[w]) begin
            st_nxt[w] = PWM_FAST;
          end else begin
            st_nxt[w]  = PWM_ON;
            cnt_nxt[w] = blank_cyc;
          end
        end
        PWM_FAST: begin
          if (~current_at_threshold[w]) begin
            st_nxt[w]  = PWM_REFILL;
            cnt_nxt[w] = off_cyc - 1'b1;
          end
        end
        PWM_REFILL: begin
          if (cnt_r[w] != '0) begin
            cnt_nxt[w] = cnt_r[w] - 1'b1;
          end else begin
            st_nxt[w]  = PWM_ON;
            cnt_nxt[w] = blank_cyc;
          end
        end
        default: begin
          st_nxt[w]  = PWM_ON;
          cnt_nxt[w] = blank_cyc;
        end
      endcase
    end

    always_ff @(posedge aclk) begin
      if (rst | ~bridge_enabled) begin
        st_r[w]   <= PWM_ON;
        cnt_r[w]  <= blank_cyc;
        gate_r[w] <= '0;
      end else begin
        st_r[w]   <= st_nxt[w];
        cnt_r[w]  <= cnt_nxt[w];
        gate_r[w] <= gate_of(st_nxt[w], neg_r[w], cfg_r.single_ended_winding_select, 1'b1);
      end
    end
  end

  assign gate_a = gate_r[0];
  assign gate_b = gate_r[1];
endmodule

// ===== sip_stepper_core_tb.sv
// bench for the stepper core
`timescale 1ns/1ps
module sip_stepper_core_tb;
  import sip_pkg::*;
  localparam logic [7:0] CTL = OFS_MAIN_CONTROL;
  localparam logic [7:0] POS = OFS_STEP_POSITION_REGISTER;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, sleep_pin, go, busy;
  logic        active_low_init_pin_n, output_gate_pin, step_pin, rotation_sense_pin, charge_pump_en, bridge_enabled;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, current_at_threshold, r;
  sip_gate_t   gate_a, gate_b;
  sip_dac_t    dac_a, dac_b;
  int          n_mismatch, samples_checked, n;
  sip_stepper_core i_dut (.*);
  sip_host_model #(.WAKE_CYC(T_WAKE_US * 1000 / CLK_PERIOD_NS)) i_host (.*);
  always #25 aclk = ~aclk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // valids held until their ready is seen at an edge
  task automatic xfer(input bit wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    bit aw, w, ar, done;
    k = 0;
    done = 0;
    if (wr) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= wd;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    while (!done && k < 200) begin
      @(negedge aclk);
      aw = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      ar = s_axi_arvalid & s_axi_arready;
      done = wr ? s_axi_bvalid : s_axi_rvalid;
      r = wr ? s_axi_bresp : s_axi_rresp;
      d = s_axi_rdata;
      k++;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (ar) s_axi_arvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    // one idle edge so a following call never raises a ready in the step that lowered it
    @(posedge aclk);
    if (!done) n_mismatch++;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    xfer(1'b1, a, wd);
    chk(32'(r), 32'(RESP_OKAY));
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(d, e);
  endtask
  task automatic wait_gate(input logic [3:0] e);
    int k;
    k = 0;
    do begin
      @(negedge aclk);
      k++;
    end while (gate_a !== e && k < 3000);
    chk(32'(gate_a), 32'(e));
  endtask
  task automatic trip(input logic [1:0] v);
    @(posedge aclk);
    current_at_threshold <= v;
  endtask
  task automatic step1();
    int k;
    k = 0;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    do begin
      @(negedge aclk);
      k++;
    end while (busy !== 1'b0 && k < 30000);
    repeat (3) @(posedge aclk);
  endtask
  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, go} = '0;
    {sleep_pin, output_gate_pin, rotation_sense_pin, current_at_threshold} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    active_low_init_pin_n = 1'b1;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdc(CTL, 32'h118);
    rdc(OFS_SECONDARY_CONFIG_REGISTER, 32'h8);
    rdc(OFS_PEAK_CURRENT_REGISTER, 32'h9);
    rdc(POS, 32'h10);
    xfer(1'b0, OFS_STATUS + 8'h4, 32'h0);
    chk(32'(r), 32'(RESP_SLVERR));
    $display("reset values done");
    for (int k = 0; k < 4; k++) begin
      output_gate_pin <= k[1];
      wr(CTL, 32'h118 | 32'(k[0]));
      @(negedge aclk);
      chk(32'(bridge_enabled), 32'(k[0] ^ k[1]));
      @(posedge aclk);
    end
    $display("enable done");
    rotation_sense_pin <= 1'b1;
    for (int m = 0; m < 6; m++) begin
      wr(CTL, 32'h100 | 32'(m << 3));
      wr(POS, 32'h10);
      step1();
      rdc(POS, 32'h10 + (32'h20 >> m));
    end
    wr(CTL, 32'h100);
    wr(POS, 32'h10);
    rotation_sense_pin <= 1'b0;
    step1();
    rdc(POS, 32'h70);
    wr(CTL, 32'h106);
    repeat (3) @(posedge aclk);
    rdc(POS, 32'h10);
    output_gate_pin <= 1'b0;
    step1();
    rdc(POS, 32'h10);
    wr(POS, 32'h30);
    repeat (6) @(posedge aclk);
    chk(32'({dac_a.neg, dac_b.neg}), 32'h1);
    chk(32'(dac_a.level), 32'(dac_b.level));
    $display("stepping done");
    output_gate_pin <= 1'b1;
    wr(POS, 32'h10);
    for (int k = 0; k < 2; k++) begin
      wr(CTL, 32'(k * 7 << 6) | 32'h18);
      wait_gate(4'h9);
      chk(32'(gate_b), 32'h9);
      trip(2'b01);
      wait_gate(4'h5);
      n = 0;
      while (gate_a === 4'h5 && n < 2000) begin
        @(negedge aclk);
        n++;
      end
      chk(32'(n > 397 + k * 700 && n < 403 + k * 700), 32'h1);
      chk(32'(gate_a), 32'h6);
      trip(2'b00);
      wait_gate(4'h5);
      wait_gate(4'h9);
      @(posedge aclk);
    end
    wr(OFS_SECONDARY_CONFIG_REGISTER, 32'h1);
    wait_gate(4'h4);
    trip(2'b01);
    wait_gate(4'h8);
    wait_gate(4'h4);
    n = 0;
    while (gate_a === 4'h4 && n < 100) begin
      @(negedge aclk);
      n++;
    end
    chk(32'(n), 32'(BLANK_MIN_CYC) + 32'h1);
    trip(2'b00);
    wr(POS, 32'h50);
    wait_gate(4'h1);
    @(posedge aclk);
    $display("regulation done");
    sleep_pin <= 1'b1;
    xfer(1'b1, OFS_PEAK_CURRENT_REGISTER, 32'h1f);
    chk(32'(r), 32'(RESP_SLVERR));
    rdc(OFS_STATUS, 32'h2);
    chk(32'({charge_pump_en, gate_a}), 32'h0);
    sleep_pin <= 1'b0;
    step1();
    rdc(POS, 32'h4c);
    wr(OFS_PEAK_CURRENT_REGISTER, 32'h1f);
    rdc(OFS_PEAK_CURRENT_REGISTER, 32'h1f);
    active_low_init_pin_n <= 1'b0;
    repeat (2) @(posedge aclk);
    active_low_init_pin_n <= 1'b1;
    @(posedge aclk);
    rdc(OFS_PEAK_CURRENT_REGISTER, 32'h9);
    rdc(POS, 32'h10);
    chk(32'(dac_a.level), 32'h708);
    $display("sleep and init done");
    finish_test();
  end
  initial begin
    repeat (80000) @(posedge aclk);
    n_mismatch++;
    finish_test();
  end
endmodule
bind sip_stepper_core sip_props i_props (.*);
